/* inc/mre_pkg.sv */
// Package: constants, types and layouts of the move / OR / conditional-return executor
package mre_pkg;

  // ==================================================================
  // T-state counts (one T-state is one clock cycle)
  localparam logic [2:0] TS_REG = 3'h2;    // Register-only forms
  localparam logic [2:0] TS_MEM = 3'h3;    // Data memory writes
  localparam logic [2:0] TS_RD = 3'h3;     // Memory read, no extra read state
  localparam logic [2:0] TS_RD_X = 3'h4;   // Memory read with extra read state
  localparam logic [2:0] TS_RET_N = 3'h2;  // Return not taken
  localparam logic [2:0] TS_RET_T = 3'h3;  // Return taken

  // ==================================================================
  // Avalon register offsets (byte addresses) and field positions
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_PC = 4'h8;
  localparam logic [3:0] OFF_STACK = 4'hC;
  localparam int CTRL_XRS = 0;             // extra_read_state_bit
  localparam int CTRL_BANK = 1;            // Two bank selection bits
  localparam int CTRL_IRQ_EN = 3;          // global_irq_enable

  // ==================================================================
  // Processor register file layout
  localparam logic [4:0] ACC_MAIN = 5'h00; // Accumulator of main bank
  localparam logic [4:0] ACC_ALT = 5'h01;  // Accumulator of alternate bank
  localparam logic [4:0] IRQ_REG = 5'h02;  // irq_control_reg
  localparam int IRQ_MASK_LSB = 0;         // Transmitter / receiver mask bits
  localparam logic [15:0] PC_RST = 16'h0000;

  // ALU flag positions and transceiver status inputs
  localparam int FL_V = 0;
  localparam int FL_C = 1;
  localparam int FL_Z = 2;
  localparam int FL_N = 3;
  localparam int RX_ACTIVE = 0;            // receiver_active_flag
  localparam int RX_ERROR = 1;             // receiver_error_flag
  localparam int RX_AVAIL = 2;             // rx_data_available
  localparam int RX_FULL = 3;              // tx_fifo_full_flag

  // ==================================================================
  // Pointer selection and indexed modes
  localparam logic [1:0] PTR_FIRST = 2'h1;
  localparam logic [1:0] PTR_SECOND = 2'h2;
  localparam logic [1:0] PTR_THIRD = 2'h3;
  localparam logic [1:0] IDX_KEEP = 2'h0;
  localparam logic [1:0] IDX_POST = 2'h1;
  localparam logic [1:0] IDX_PRE = 2'h2;
  localparam logic [1:0] G_KEEP = 2'h0;
  localparam logic [1:0] G_RESTORE = 2'h1;
  localparam logic [1:0] G_SET = 2'h2;
  localparam logic [1:0] G_CLEAR = 2'h3;

  // ==================================================================
  // Types
  typedef enum logic [3:0] {OP_MOV_MR, OP_MOV_IR, OP_MOV_IM, OP_MOV_RR, OP_MOV_RM,
                            OP_OR_I, OP_OR_ACC_R, OP_OR_ACC_M, OP_RET} op_t;
  typedef enum logic [1:0] {F_IDX, F_REL_A, F_REL_N} form_t;
  typedef enum logic {S_IDLE, S_RUN} st_t;

  typedef struct packed {
    op_t op;                           // Instruction kind
    form_t form;                       // Memory address form
    logic [1:0] ptr_sel;               // Pointer selection
    logic [1:0] idx_mode;              // Indexed pointer modification
    logic [4:0] src;                   // Source register
    logic [4:0] dst;                   // Destination register
    logic [7:0] imm;                   // Literal or offset
    logic [2:0] flag_sel;              // Condition flag selector
    logic flag_val;                    // Required flag state
    logic [1:0] g;                     // Interrupt enable operand
    logic restore_flags_operand;       // Restore flags and banks
  } instr_t;

  typedef struct packed {
    logic [1:0] bank;
    logic [3:0] flags;
    logic global_irq_enable;
    logic [15:0] pc;
  } stk_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } mem_req_t;

endpackage

/* verilog/move_or_return_exec.sv */
// Module: executor for data moves, OR instructions and conditional returns
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
// ====================================================================
module move_or_return_exec
  import mre_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic srst,
  // Avalon-MM register slave
  input logic [3:0] av_address,
  input logic av_read,
  input logic av_write,
  input logic [31:0] av_writedata,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  // Decoded instruction stream
  input instr_t instr,
  input logic instr_valid,
  output logic instr_ready,
  output logic done,
  // Data memory
  output mem_req_t mem,
  input logic [7:0] mem_rdata,
  // Transceiver status flags and interrupt masks
  input logic [3:0] rx_flags,
  output logic [1:0] irq_mask
);

  // ==================================================================
  // State
  typedef struct packed {
    st_t st;                      // Idle or executing
    logic [2:0] cnt;              // T-state counter
    logic [2:0] tlen;             // T-states of current instruction
    instr_t ins;                  // Latched instruction
    logic take;                   // Return condition held
    logic [7:0] data;             // Memory write byte
    logic [31:0][7:0] regs;       // Active processor registers
    logic [2:0][15:0] ptr;        // Three 16-bit pointers
    logic [3:0] flags;            // N Z C V
    logic global_irq_enable;                    // global_irq_enable
    logic [1:0] bank;             // Bank selections
    logic [15:0] pc;              // Program counter
    stk_t [3:0] stk;              // Internal address stack
    logic [1:0] sp;               // Next free stack slot
    logic xrs;                    // extra_read_state_bit
    logic ready;
    logic done;
    logic wait_r;
    logic [31:0] rdata;
    mem_req_t mem;
    logic [1:0] irq_mask;
  } state_t;

  state_t r;
  state_t n;

  // ==================================================================
  // Helpers
  // Pointer slot; code 00 is treated as the first pointer
  function automatic logic [1:0] pidx(input logic [1:0] sel);
    pidx = (sel == PTR_SECOND) ? 2'h1 : (sel == PTR_THIRD) ? 2'h2 : 2'h0;
  endfunction

  // Flag referenced by a return's selector
  function automatic logic flag_at(input logic [2:0] sel, input logic [3:0] fl, input logic [3:0] rx);
    case (sel)
      3'h0: flag_at = fl[FL_Z];
      3'h1: flag_at = fl[FL_C];
      3'h2: flag_at = fl[FL_V];
      3'h3: flag_at = fl[FL_N];
      3'h4: flag_at = rx[RX_ACTIVE];
      3'h5: flag_at = rx[RX_ERROR];
      3'h6: flag_at = rx[RX_AVAIL];
      default: flag_at = rx[RX_FULL];
    endcase
  endfunction

  // Short operand forms use only the low sixteen registers
  function automatic logic is_short(input instr_t i);
    is_short = (i.op == OP_MOV_IR) || (i.op == OP_OR_I) ||
               (i.form == F_REL_N && (i.op == OP_MOV_MR || i.op == OP_MOV_RM));
  endfunction

  logic [7:0] acc_now;
  stk_t top_now;
  logic accept;
  assign acc_now = r.regs[r.bank[0] ? ACC_ALT : ACC_MAIN];
  assign top_now = r.stk[r.sp - 2'h1];
  assign accept = instr_valid && r.st == S_IDLE;

  // ==================================================================
  // Next state
  always_comb begin
    logic [15:0] p;
    logic [7:0] v;
    instr_t d;
    p = r.ptr[pidx(instr.ptr_sel)];
    v = 8'h00;
    d = instr;
    n = r;
    n.done = 1'b0;
    n.mem.rd = 1'b0;
    n.mem.wr = 1'b0;
    n.wait_r = 1'b1;

    // Bus slave: one wait cycle, then a one-cycle answer
    if ((av_read || av_write) && r.wait_r) begin
      n.wait_r = 1'b0;
      n.rdata = 32'h0000_0000;
      if (!av_write) begin
        case (av_address)
          OFF_CTRL: n.rdata = {28'h0000000, r.global_irq_enable, r.bank, r.xrs};
          OFF_STATUS: n.rdata = {25'h0000000, r.sp, r.st == S_RUN, r.flags};
          OFF_PC: n.rdata = {16'h0000, r.pc};
          OFF_STACK: n.rdata = {9'h000, top_now};
          default: n.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Write lands at the edge where the master sees waitrequest low
    if (av_write && !r.wait_r) begin
      case (av_address)
        OFF_CTRL: begin
          n.xrs = av_writedata[CTRL_XRS];
          n.bank = av_writedata[CTRL_BANK +: 2];
          n.global_irq_enable = av_writedata[CTRL_IRQ_EN];
        end
        OFF_PC: n.pc = av_writedata[15:0];
        // A write pushes one stack entry, as a call would
        OFF_STACK: begin
          n.stk[r.sp] = av_writedata[22:0];
          n.sp = r.sp + 2'h1;
        end
        default: ;
      endcase
    end

    case (r.st)
      // Take the instruction, start its memory access
      S_IDLE: begin
        if (instr_valid) begin
          if (is_short(instr)) begin
            d.dst = {1'b0, instr.dst[3:0]};
            d.src = {1'b0, instr.src[3:0]};
          end
          case (instr.form)
            F_REL_A: n.mem.addr = p + {8'h00, acc_now};
            F_REL_N: n.mem.addr = r.ptr[pidx(PTR_THIRD)] + {8'h00, instr.imm};
            default: n.mem.addr = (instr.idx_mode == IDX_PRE) ? p + 16'h0001 : p;
          endcase
          n.mem.rd = (instr.op == OP_MOV_MR);
          n.mem.wr = (instr.op == OP_MOV_IM) || (instr.op == OP_MOV_RM) || (instr.op == OP_OR_ACC_M);
          // Pointer moves now, so the next access sees it
          if (instr.form == F_IDX && instr.idx_mode != IDX_KEEP && (n.mem.rd || n.mem.wr)) begin
            n.ptr[pidx(instr.ptr_sel)] = p + 16'h0001;
          end
          case (instr.op)
            OP_MOV_IM: n.data = instr.imm;
            OP_OR_ACC_M: n.data = r.regs[d.src] | acc_now;
            default: n.data = r.regs[d.src];
          endcase
          n.mem.wdata = n.data;
          n.take = (flag_at(instr.flag_sel, r.flags, rx_flags) == instr.flag_val);
          case (instr.op)
            OP_MOV_MR: n.tlen = r.xrs ? TS_RD_X : TS_RD;
            OP_MOV_IM, OP_MOV_RM, OP_OR_ACC_M: n.tlen = TS_MEM;
            OP_RET: n.tlen = n.take ? TS_RET_T : TS_RET_N;
            default: n.tlen = TS_REG;
          endcase
          n.ins = d;
          n.st = S_RUN;
          n.cnt = 3'h1;
          n.ready = 1'b0;
        end
      end
      // Count T-states, retire on the last one
      S_RUN: begin
        if (r.cnt == r.tlen - 3'h1) begin
          n.st = S_IDLE;
          n.done = 1'b1;
          n.ready = 1'b1;
          n.pc = r.pc + 16'h0001;
          case (r.ins.op)
            OP_MOV_MR: n.regs[r.ins.dst] = mem_rdata;
            OP_MOV_IR: n.regs[r.ins.dst] = r.ins.imm;
            OP_MOV_RR: n.regs[r.ins.dst] = r.regs[r.ins.src];
            OP_OR_I: begin
              v = r.regs[r.ins.dst] | r.ins.imm;
              n.regs[r.ins.dst] = v;
            end
            OP_OR_ACC_R: begin
              v = r.regs[r.ins.src] | acc_now;
              n.regs[r.ins.dst] = v;
            end
            OP_OR_ACC_M: v = r.data;
            OP_RET: begin
              if (r.take) begin
                n.pc = top_now.pc;
                n.sp = r.sp - 2'h1;
                case (r.ins.g)
                  G_RESTORE: n.global_irq_enable = top_now.global_irq_enable;
                  G_SET: n.global_irq_enable = 1'b1;
                  G_CLEAR: n.global_irq_enable = 1'b0;
                  default: ;
                endcase
                if (r.ins.restore_flags_operand) begin
                  n.flags = top_now.flags;
                  n.bank = top_now.bank;
                end
              end
            end
            default: ;
          endcase
          // Only OR forms set N and Z from a result; moves leave flags alone
          if (r.ins.op == OP_OR_I || r.ins.op == OP_OR_ACC_R || r.ins.op == OP_OR_ACC_M) begin
            n.flags[FL_N] = v[7];
            n.flags[FL_Z] = (v == 8'h00);
          end
        end else begin
          n.cnt = r.cnt + 3'h1;
        end
      end
      default: n.st = S_IDLE;
    endcase
    // Mask bits follow the interrupt control register
    n.irq_mask = n.regs[IRQ_REG][IRQ_MASK_LSB +: 2];
  end

  // ==================================================================
  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
      r.pc <= PC_RST;
      r.ready <= 1'b1;
      r.wait_r <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flip-flops
  assign av_readdata = r.rdata;
  assign av_waitrequest = r.wait_r;
  assign instr_ready = r.ready;
  assign done = r.done;
  assign mem = r.mem;
  assign irq_mask = r.irq_mask;

  // ==================================================================
  // Assertions
  property p_rd_short;
    @(posedge clk) disable iff (srst) accept && instr.op == OP_MOV_MR && !r.xrs |-> ##2 !r.done ##1 r.done;
  endproperty
  a_rd_short: assert property (p_rd_short) else $error("short read length wrong");

  property p_rd_long;
    @(posedge clk) disable iff (srst) accept && instr.op == OP_MOV_MR && r.xrs |-> ##3 !r.done ##1 r.done;
  endproperty
  a_rd_long: assert property (p_rd_long) else $error("long read length wrong");

  property p_imm_reg;
    @(posedge clk) disable iff (srst)
      accept && instr.op == OP_MOV_IR |-> ##2 (r.done && r.regs[r.ins.dst] == r.ins.imm && r.flags == $past(r.flags));
  endproperty
  a_imm_reg: assert property (p_imm_reg) else $error("literal move to register wrong");

  property p_imm_mem;
    @(posedge clk) disable iff (srst)
      accept && instr.op == OP_MOV_IM |=> r.mem.wr && r.mem.wdata == $past(instr.imm) ##2 r.done;
  endproperty
  a_imm_mem: assert property (p_imm_mem) else $error("literal move to memory wrong");

  property p_or_flags;
    @(posedge clk) disable iff (srst) r.done && r.ins.op == OP_OR_I |->
      r.flags[FL_Z] == (r.regs[r.ins.dst] == 8'h00) && r.flags[FL_N] == r.regs[r.ins.dst][7];
  endproperty
  a_or_flags: assert property (p_or_flags) else $error("OR literal flags wrong");

  property p_ret_skip;
    @(posedge clk) disable iff (srst)
      accept && instr.op == OP_RET && flag_at(instr.flag_sel, r.flags, rx_flags) != instr.flag_val
      |-> ##2 (r.done && r.pc == $past(r.pc, 2) + 16'h0001);
  endproperty
  a_ret_skip: assert property (p_ret_skip) else $error("untaken return wrong");

  property p_ret_take;
    @(posedge clk) disable iff (srst)
      accept && instr.op == OP_RET && flag_at(instr.flag_sel, r.flags, rx_flags) == instr.flag_val && !av_write
      |-> ##3 (r.done && r.pc == $past(top_now.pc, 3));
  endproperty
  a_ret_take: assert property (p_ret_take) else $error("taken return wrong");

  property p_gie_set;
    @(posedge clk) disable iff (srst) r.done && r.ins.op == OP_RET && r.take && r.ins.g == G_SET |-> r.global_irq_enable;
  endproperty
  a_gie_set: assert property (p_gie_set) else $error("interrupt enable not set");

  property p_mask;
    @(posedge clk) disable iff (srst) ##1 1'b1 |-> r.irq_mask == $past(n.regs[IRQ_REG][1:0]);
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt mask mismatch");

  property p_post_inc;
    @(posedge clk) disable iff (srst)
      accept && instr.op == OP_MOV_RM && instr.form == F_IDX && instr.idx_mode == IDX_POST
      |=> r.ptr[pidx($past(instr.ptr_sel))] == r.mem.addr + 16'h0001;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("pointer not incremented");

  c_read_long: cover property (@(posedge clk) accept && instr.op == OP_MOV_MR && r.xrs);
  c_ret_taken: cover property (@(posedge clk) r.done && r.ins.op == OP_RET && r.take);
  c_or_acc_mem: cover property (@(posedge clk) r.done && r.ins.op == OP_OR_ACC_M);

endmodule

/* tb/data_mem_model.sv */
// Byte-wide data memory model facing the executor
`timescale 1ns/100ps
module data_mem_model
  import mre_pkg::*;
(
  // Clock
  input logic clk,
  // Request from the executor and speed choice
  input mem_req_t mem,
  input logic slow,
  // Read answer
  output logic [7:0] mem_rdata
);
  // ==========
  // Storage and read timing
  logic [7:0] ram [0:65535]; // Whole 16-bit address space
  logic hold = 1'b0; // Read byte must stand one more cycle
  logic pend = 1'b0; // Slow answer due at the next edge
  logic [15:0] paddr = 16'h0000; // Address kept for the slow answer
  initial mem_rdata = 8'h00;
  // One cycle latency, two when slow; a byte stands two cycles only
  always @(posedge clk) begin
    if (mem.wr === 1'b1) begin
      ram[mem.addr] <= mem.wdata;
    end
    if ((mem.rd === 1'b1 && !slow) || pend) begin
      mem_rdata <= ram[pend ? paddr : mem.addr];
      hold <= 1'b1;
    end else if (hold) begin
      hold <= 1'b0;
    end else begin
      // Not driven: a changing pattern, so stale data never looks valid
      mem_rdata <= ~mem_rdata;
    end
    pend <= (mem.rd === 1'b1) && slow;
    paddr <= mem.addr;
  end
endmodule

/* tb/move_or_return_exec_test.sv */
// Self-checking bench of the move, OR and conditional-return executor
`timescale 1ns/100ps
module move_or_return_exec_test;
  import mre_pkg::*;
  // ==========
  // Design ports
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] av_address = 4'h0;
  logic av_read = 1'b0;
  logic av_write = 1'b0;
  logic [31:0] av_writedata = 32'h0;
  logic [31:0] av_readdata;
  logic av_waitrequest, instr_ready, done;
  instr_t instr = '0;
  logic instr_valid = 1'b0;
  logic slow = 1'b0; // Memory answers one cycle late
  mem_req_t mem;
  logic [7:0] mem_rdata;
  logic [3:0] rx_flags = 4'h0;
  logic [1:0] irq_mask;
  // ==========
  // Expectation queues and counters
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int lat = 0; // Edges since the last acceptance
  logic [23:0] wq[$]; // Memory writes {addr, data}
  int tq[$]; // Instruction lengths in T-states
  logic [63:0] rq[$]; // Register reads {mask, value}
  logic [63:0] e;
  // Reference state
  logic [7:0] r [0:31];
  logic [15:0] p [0:3];
  logic [3:0] fl; // {N, Z, C, V}
  logic [1:0] bank;
  logic global_irq_enable, xrs;
  logic [15:0] pc;
  stk_t stk[$];
  logic [7:0] bm [logic [15:0]];
  instr_t ri;
  always #4 clk = ~clk;
  move_or_return_exec uut (.clk(clk), .srst(srst), .av_address(av_address), .av_read(av_read),
    .av_write(av_write), .av_writedata(av_writedata), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .done(done), .mem(mem), .mem_rdata(mem_rdata),
    .rx_flags(rx_flags), .irq_mask(irq_mask));
  data_mem_model mdl (.clk(clk), .mem(mem), .slow(slow), .mem_rdata(mem_rdata));
  // ==========
  // Checking and closing
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watcher: oldest note against each result as it appears
  always @(posedge clk) begin
    cycles <= cycles + 1;
    lat <= (instr_valid === 1'b1 && instr_ready === 1'b1) ? 1 : lat + 1;
    if (mem.wr === 1'b1) chk(wq.size() != 0 && {mem.addr, mem.wdata} === wq.pop_front(), "memory write");
    if (done === 1'b1) chk(tq.size() != 0 && lat == tq.pop_front(), "instruction length");
    if (av_read === 1'b1 && av_waitrequest === 1'b0 && rq.size() != 0) begin
      e = rq.pop_front();
      chk((av_readdata & e[63:32]) === (e[31:0] & e[63:32]), "register read");
    end
    // Hang guard well above the expected run length
    if (cycles == 6000) begin
      bad_count++;
      stop_test();
    end
  end
  // ==========
  // Bus and instruction drivers
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    av_address <= a;
    av_writedata <= d;
    if (wr) av_write <= 1'b1;
    else av_read <= 1'b1;
    do @(posedge clk); while (av_waitrequest !== 1'b0);
    av_write <= 1'b0;
    av_read <= 1'b0;
    // One idle edge so the strobe is never raised in the same step
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
    rq.push_back({m, v});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wr_ctrl(input logic x, input logic [1:0] b);
    xrs = x;
    bank = b;
    bus(1'b1, OFF_CTRL, {28'h0, global_irq_enable, b, x});
  endtask
  task automatic push;
    stk_t s;
    s = 23'($urandom);
    stk.push_back(s);
    bus(1'b1, OFF_STACK, {9'h0, s});
    rd(OFF_STACK, 32'h7FFFFF, {9'h0, s});
  endtask
  function automatic instr_t mk(op_t o, form_t f, logic [1:0] ps, logic [1:0] m, logic [4:0] s, logic [4:0] d,
                                logic [7:0] n);
    mk = '{o, f, ps, m, s, d, n, 3'h0, 1'b0, 2'h0, 1'b0};
  endfunction
  // Update the reference, note the results, then present the instruction
  task automatic run(input instr_t i);
    logic [7:0] acc, v;
    logic [15:0] a;
    logic [1:0] ps;
    logic [4:0] d, s;
    logic [3:0] rx, cf;
    stk_t t;
    int n;
    rx = 4'($urandom);
    acc = r[{4'h0, bank[0]}];
    ps = (i.ptr_sel == 2'h0) ? PTR_FIRST : i.ptr_sel;
    s = i.src;
    d = i.dst;
    // Short operands wrap to the low sixteen registers
    if (i.op == OP_MOV_IR || i.op == OP_OR_I || i.form == F_REL_N) begin
      s[4] = 1'b0;
      d[4] = 1'b0;
    end
    a = p[ps] + ((i.idx_mode == IDX_PRE) ? 16'h1 : 16'h0);
    if (i.form == F_REL_A) a = p[ps] + {8'h00, acc};
    if (i.form == F_REL_N) a = p[PTR_THIRD] + {8'h00, i.imm};
    if (i.form == F_IDX && i.idx_mode != IDX_KEEP) p[ps] = p[ps] + 16'h1;
    v = (i.op == OP_OR_I) ? (r[d] | i.imm) : (r[s] | acc);
    cf = {fl[FL_N], fl[FL_V], fl[FL_C], fl[FL_Z]};
    n = 2;
    pc = pc + 16'h1;
    case (i.op)
      OP_MOV_MR: begin
        n = xrs ? 4 : 3;
        r[d] = bm[a];
      end
      OP_MOV_IR: r[d] = i.imm;
      OP_MOV_IM, OP_MOV_RM, OP_OR_ACC_M: begin
        n = 3;
        a = a;
        bm[a] = (i.op == OP_MOV_IM) ? i.imm : (i.op == OP_MOV_RM) ? r[s] : v;
        wq.push_back({a, bm[a]});
      end
      OP_MOV_RR: r[d] = r[s];
      OP_OR_I, OP_OR_ACC_R: r[d] = v;
      default: begin
        // Return: the flag is looked at when the instruction is taken in
        if ((i.flag_sel[2] ? rx[i.flag_sel[1:0]] : cf[i.flag_sel[1:0]]) == i.flag_val) begin
          n = 3;
          t = stk.pop_back();
          pc = t.pc;
          if (i.g == G_RESTORE) global_irq_enable = t.global_irq_enable;
          else if (i.g[1]) global_irq_enable = ~i.g[0];
          if (i.restore_flags_operand) begin
            fl = t.flags;
            bank = t.bank;
          end
        end
      end
    endcase
    if (i.op inside {OP_OR_I, OP_OR_ACC_R, OP_OR_ACC_M}) begin
      fl[FL_N] = v[7];
      fl[FL_Z] = (v == 8'h00);
    end
    tq.push_back(n);
    rx_flags <= rx;
    instr <= i;
    instr_valid <= 1'b1;
    do @(posedge clk); while (instr_ready !== 1'b1);
  endtask
  task automatic drain;
    instr_valid <= 1'b0;
    do @(posedge clk); while (instr_ready !== 1'b1);
  endtask
  // ==========
  // Main sequence
  initial begin
    e = 64'($urandom(32'h2C6A5FCE));
    foreach (r[k]) r[k] = 8'h00;
    foreach (p[k]) p[k] = 16'h0000;
    fl = 4'h0;
    bank = 2'h0;
    global_irq_enable = 1'b0;
    xrs = 1'b0;
    pc = 16'h0000;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // Reset values, a read-only write and an unmapped read
    rd(OFF_CTRL, 32'hF, 32'h0);
    rd(OFF_PC, 32'hFFFF, 32'h0);
    bus(1'b1, OFF_STATUS, 32'hFFFFFFFF);
    rd(OFF_STATUS, 32'h7F, 32'h0);
    rd(4'h2, 32'hFFFFFFFF, 32'h0);
    // Back-to-back literals, one through a wrapping short operand
    for (int k = 0; k < 8; k++) run(mk(OP_MOV_IR, F_IDX, 2'h0, 2'h0, 5'h0, 5'(k), 8'($urandom)));
    run(mk(OP_MOV_IR, F_IDX, 2'h0, 2'h0, 5'h0, 5'h13, 8'($urandom)));
    // Every pointer with every indexed mode
    for (int k = 1; k < 4; k++) begin
      for (int m = 0; m < 3; m++) begin
        run(mk(OP_MOV_RM, F_IDX, 2'(k), 2'(m), 5'(k + m), 5'h0, 8'h00));
      end
    end
    run(mk(OP_MOV_RR, F_IDX, 2'h0, 2'h0, 5'h3, 5'h14, 8'h00));
    run(mk(OP_MOV_RM, F_IDX, 2'h1, 2'h0, 5'h14, 5'h0, 8'h00));
    run(mk(OP_MOV_IM, F_IDX, 2'h2, 2'h0, 5'h0, 5'h0, 8'($urandom)));
    run(mk(OP_MOV_MR, F_IDX, 2'h2, 2'h1, 5'h0, 5'h9, 8'h00));
    run(mk(OP_MOV_RM, F_IDX, 2'h2, 2'h0, 5'h9, 5'h0, 8'h00));
    // Relative forms; a large accumulator must not sign-extend
    run(mk(OP_MOV_IR, F_IDX, 2'h0, 2'h0, 5'h0, 5'h0, 8'hF0));
    run(mk(OP_MOV_RM, F_REL_A, 2'h1, 2'h0, 5'h5, 5'h0, 8'h00));
    run(mk(OP_MOV_MR, F_REL_A, 2'h1, 2'h0, 5'h0, 5'h1A, 8'h00));
    run(mk(OP_MOV_RM, F_REL_N, 2'h3, 2'h0, 5'h1A, 5'h0, 8'h80));
    run(mk(OP_MOV_MR, F_REL_N, 2'h3, 2'h0, 5'h0, 5'h1B, 8'h80));
    run(mk(OP_MOV_RM, F_IDX, 2'h1, 2'h0, 5'hB, 5'h0, 8'h00));
    // Extra read state with a slow memory
    drain();
    slow <= 1'b1;
    wr_ctrl(1'b1, 2'h0);
    run(mk(OP_MOV_MR, F_REL_A, 2'h1, 2'h0, 5'h0, 5'hC, 8'h00));
    run(mk(OP_MOV_RM, F_IDX, 2'h1, 2'h0, 5'hC, 5'h0, 8'h00));
    // OR forms and their flags
    run(mk(OP_OR_I, F_IDX, 2'h0, 2'h0, 5'h0, 5'h2, 8'h03));
    run(mk(OP_OR_I, F_IDX, 2'h0, 2'h0, 5'h0, 5'hD, 8'h00));
    drain();
    rd(OFF_STATUS, 32'hF, {28'h0, fl});
    wr_ctrl(1'b1, 2'h1);
    run(mk(OP_OR_ACC_R, F_IDX, 2'h0, 2'h0, 5'h4, 5'h16, 8'h00));
    run(mk(OP_MOV_RM, F_IDX, 2'h1, 2'h0, 5'h16, 5'h0, 8'h00));
    run(mk(OP_OR_ACC_M, F_IDX, 2'h1, 2'h1, 5'h6, 5'h0, 8'h00));
    run(mk(OP_OR_I, F_IDX, 2'h0, 2'h0, 5'h0, 5'h7, 8'h80));
    run(mk(OP_MOV_RM, F_IDX, 2'h1, 2'h0, 5'h7, 5'h0, 8'h00));
    drain();
    rd(OFF_STATUS, 32'hF, {28'h0, fl});
    // Returns over all selectors, interrupt codes and restore choices
    for (int k = 0; k < 16; k++) begin
      if (stk.size() < 2) push();
      ri = mk(OP_RET, F_IDX, 2'h0, 2'h0, 5'h0, 5'h0, 8'h00);
      ri.flag_sel = 3'(k);
      ri.flag_val = 1'($urandom);
      ri.g = 2'(k);
      ri.restore_flags_operand = k[2] ^ k[3];
      run(ri);
      drain();
      rd(OFF_PC, 32'hFFFF, {16'h0, pc});
      rd(OFF_CTRL, 32'hF, {28'h0, global_irq_enable, bank, xrs});
      rd(OFF_STATUS, 32'hF, {28'h0, fl});
    end
    chk(irq_mask === r[2][1:0], "interrupt mask");
    repeat (2) @(posedge clk);
    chk(wq.size() == 0 && tq.size() == 0 && rq.size() == 0, "results missing");
    stop_test();
  end
endmodule
